/* design/svi_pkg.sv */
// Shared constants and types of the supervisor two-wire slave
`default_nettype none
package svi_pkg;
   // ==========================================
   // Address byte layout
   localparam logic [3:0] DEV_ID = 4'ha; // Fixed upper nibble
   localparam logic FIX_LVL = 1'b0; // Level of the fixed bit below the nibble
   localparam int ID_MSB = 7; // Top of the fixed nibble
   localparam int ID_LSB = 4; // Bottom of the fixed nibble
   localparam int FIX_BIT = 3; // Fixed zero bit
   localparam int SEL_BIT = 2; // pin_matched_addr_bit position
   localparam int DIR_BIT = 0; // direction_bit position, 1 = read
   // ==========================================
   // Command codes
   localparam logic [7:0] CMD_BLK_WR = 8'hc0; // Block write entry
   localparam logic [7:0] CMD_BLK_RD = 8'hc1; // Block read entry
   localparam logic [7:0] CMD_REBOOT = 8'hc4; // Reload from nonvolatile store
   localparam logic [7:0] EEP_LSB_LO = 8'h80; // First EEPROM low-byte preset code
   localparam logic [7:0] EEP_LSB_HI = 8'h82; // Last EEPROM low-byte preset code
   // ==========================================
   // Pointer map
   localparam logic [7:0] REG_TOP = 8'h2f; // Last register, read-only
   localparam logic [7:0] USR_BOT = 8'h40; // First user EEPROM byte
   localparam logic [7:0] EEP_TOP = 8'h9f; // Last configuration EEPROM byte
   localparam logic [7:0] PTR_RST = 8'h00; // Pointer after reset
   localparam logic [7:0] PTR_STEP = 8'h01; // Pointer advance
   localparam logic [7:0] IDLE_BYTE = 8'hff; // Sent beyond the block length
   // ==========================================
   // Bit and block counts
   localparam logic [3:0] BIT_ACK = 4'h8; // Bits before the ninth clock
   localparam logic [3:0] BIT_ZERO = 4'h0; // Start of a byte
   localparam logic [3:0] BIT_STEP = 4'h1; // Bit counter step
   localparam logic [4:0] BLK_LEN = 5'h10; // Block length, also the count byte
   localparam logic [4:0] CNT_STEP = 5'h01; // Block counter step
   localparam logic [4:0] CNT_ZERO = 5'h00; // Block counter empty
   // ==========================================
   // Protocol states
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001, // Bus free
      ST_ADDR = 9'h002, // Receiving address byte
      ST_CMD  = 9'h004, // Receiving command byte
      ST_WDAT = 9'h008, // Legal pointer held, data or end may follow
      ST_BCNT = 9'h010, // Block write byte count
      ST_BWR  = 9'h020, // Block write data
      ST_TX   = 9'h040, // Sending to master
      ST_HOLD = 9'h080, // Block read or reboot code held
      ST_SKIP = 9'h100  // Refused, single write done or master nack, wait for start or stop
   } svi_state_e;
   // Write port toward the register bank
   typedef struct packed {
      logic [7:0] addr; // Target location
      logic [7:0] data; // Byte to store
   } svi_wr_s;
endpackage
`default_nettype wire

/* design/svi_slave.sv */
// Two-wire slave protocol engine of the supervisor
// Operation
// - Acknowledge received bytes on ninth clock
// - Release line on ninth clock when sending
// - Refuse command while busy or illegal
// - Match fixed nibble; low bit is direction
// - Compare select bit to pin; ignore next
// - Lone byte then stop loads pointer
// - Acknowledge block write code, expect more
// - Stop after block write code: pointer kept
// - Block read code enters block read mode
// - Reboot code alone reloads configuration
// - Single write stores only valid codes
// - Refuse invalid or busy write code
// - Codes 80h-82h preset EEPROM low byte
// - Block write one to sixteen bytes
// - Block pointer saturates at last location
// - User block runs on, holds at top
// - Read byte after command and restart
// - Bare read returns pointer location
// - Block read sends count sixteen, data
// - Only legal pointer ranges accepted
// - Pointer advances after reads, saturating
`default_nettype none
module svi_slave (
   input wire logic ref_clk, // System clock, 250 MHz
   input wire logic rst, // Synchronous reset, high
   input wire logic clkEn, // Freezes all state while low
   input wire logic sclIn, // Serial clock pin
   input wire logic sdaIn, // Serial data pin level
   output logic sdaOut, // Serial data drive level
   output logic sdaOe, // Serial data drive enable
   input wire logic addrSelectPin, // Hardwired address select
   input wire logic busy, // EEPROM write or reboot ongoing
   input wire logic [7:0] rdData, // Byte at rdAddr
   output logic [7:0] rdAddr, // Internal address pointer
   output svi_pkg::svi_wr_s wrPort, // Write address and data
   output logic wrStb, // Store wrPort, one cycle
   output logic eepLsbLoad, // EEPROM low byte preset, one cycle
   output logic rebootReq // Reload configuration, one cycle
);
   // ==========================================
   // Pointer helpers
   // Legal pointer: registers or either EEPROM area
   function automatic logic ptrLegal(input logic [7:0] p);
      ptrLegal = (p <= svi_pkg::REG_TOP) || (p >= svi_pkg::USR_BOT && p <= svi_pkg::EEP_TOP);
   endfunction
   // Advance with saturation; user top runs into config area
   function automatic logic [7:0] ptrNext(input logic [7:0] p);
      if (p == svi_pkg::REG_TOP || p == svi_pkg::EEP_TOP) begin
         ptrNext = p;
      end else begin
         ptrNext = p + svi_pkg::PTR_STEP;
      end
   endfunction

   // ==========================================
   // Pin synchronisers
   logic sclS1_q, sclS2_q, sclP_q; // Clock chain and history
   logic sdaS1_q, sdaS2_q, sdaP_q; // Data chain and history
   logic selS1_q, selS2_q; // Select pin chain
   // Two flops per pin; history flop only for edges
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclS1_q <= 1'b1;
         sclS2_q <= 1'b1;
         sclP_q <= 1'b1;
         sdaS1_q <= 1'b1;
         sdaS2_q <= 1'b1;
         sdaP_q <= 1'b1;
         selS1_q <= 1'b0;
         selS2_q <= 1'b0;
      end else if (clkEn) begin
         sclS1_q <= sclIn;
         sclS2_q <= sclS1_q;
         sclP_q <= sclS2_q;
         sdaS1_q <= sdaIn;
         sdaS2_q <= sdaS1_q;
         sdaP_q <= sdaS2_q;
         selS1_q <= addrSelectPin;
         selS2_q <= selS1_q;
      end
   end

   // Bus events, all from synchronised levels
   logic sclRise, sclFall, startDet, stopDet;
   assign sclRise = sclS2_q && !sclP_q;
   assign sclFall = !sclS2_q && sclP_q;
   // Data moves while clock high mark frame edges
   assign startDet = sclS2_q && sclP_q && sdaP_q && !sdaS2_q;
   assign stopDet = sclS2_q && sclP_q && !sdaP_q && sdaS2_q;

   // ==========================================
   // Protocol state
   svi_pkg::svi_state_e state_q, state_d; // Protocol phase
   logic [3:0] bitCnt_q, bitCnt_d; // Bits seen in this byte
   logic [7:0] sh_q, sh_d; // Receive shifter
   logic [7:0] tx_q, tx_d; // Transmit shifter
   logic [7:0] cmd_q, cmd_d; // Held command code
   logic [7:0] ptr_q, ptr_d; // Address pointer
   logic [4:0] cnt_q, cnt_d; // Block bytes left
   logic oe_q, oe_d; // Data line drive
   logic ackOurs_q, ackOurs_d; // We drive the ninth bit
   logic mAck_q, mAck_d; // Master acknowledged last byte
   logic blkRd_q, blkRd_d; // Block read mode
   logic cntByte_q, cntByte_d; // Count byte still to send
   svi_pkg::svi_wr_s wr_q, wr_d; // Write port
   logic wrStb_q, wrStb_d; // Write strobe
   logic eep_q, eep_d; // EEPROM low byte strobe
   logic boot_q, boot_d; // Reboot strobe
   logic addrHit; // Address byte selects us
   logic [7:0] txLoad; // Next byte to send

   assign addrHit = (sh_q[svi_pkg::ID_MSB:svi_pkg::ID_LSB] == svi_pkg::DEV_ID) &&
                    (sh_q[svi_pkg::FIX_BIT] == svi_pkg::FIX_LVL) &&
                    (sh_q[svi_pkg::SEL_BIT] == selS2_q);

   // Count byte first, then data, then filler past the block
   always_comb begin
      if (cntByte_q) begin
         txLoad = {3'h0, svi_pkg::BLK_LEN};
      end else if (blkRd_q && cnt_q == svi_pkg::CNT_ZERO) begin
         txLoad = svi_pkg::IDLE_BYTE;
      end else begin
         txLoad = rdData;
      end
   end

   // Next-state logic for the whole protocol
   always_comb begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      sh_d = sh_q;
      tx_d = tx_q;
      cmd_d = cmd_q;
      ptr_d = ptr_q;
      cnt_d = cnt_q;
      oe_d = oe_q;
      ackOurs_d = ackOurs_q;
      mAck_d = mAck_q;
      blkRd_d = blkRd_q;
      cntByte_d = cntByte_q;
      wr_d = wr_q;
      wrStb_d = 1'b0;
      eep_d = 1'b0;
      boot_d = 1'b0;
      if (startDet) begin
         // Restart drops any partial byte
         state_d = svi_pkg::ST_ADDR;
         bitCnt_d = svi_pkg::BIT_ZERO;
         oe_d = 1'b0;
         ackOurs_d = 1'b0;
         if (state_q == svi_pkg::ST_WDAT) begin
            ptr_d = cmd_q;
         end
      end else if (stopDet) begin
         // Stop ends the frame and block read mode
         state_d = svi_pkg::ST_IDLE;
         bitCnt_d = svi_pkg::BIT_ZERO;
         oe_d = 1'b0;
         ackOurs_d = 1'b0;
         blkRd_d = 1'b0;
         if (state_q == svi_pkg::ST_WDAT) begin
            ptr_d = cmd_q;
         end
         if (state_q == svi_pkg::ST_HOLD && cmd_q == svi_pkg::CMD_REBOOT) begin
            boot_d = 1'b1;
         end
      end else if (state_q != svi_pkg::ST_IDLE && sclRise) begin
         if (bitCnt_q == svi_pkg::BIT_ACK) begin
            // Ninth clock high: sample master answer
            bitCnt_d = svi_pkg::BIT_ZERO;
            if (!ackOurs_q && state_q == svi_pkg::ST_TX) begin
               mAck_d = !sdaS2_q;
               if (cntByte_q) begin
                  cntByte_d = 1'b0;
               end else begin
                  ptr_d = ptrNext(ptr_q);
                  if (blkRd_q && cnt_q != svi_pkg::CNT_ZERO) begin
                     cnt_d = cnt_q - svi_pkg::CNT_STEP;
                  end
               end
            end
         end else begin
            sh_d = {sh_q[6:0], sdaS2_q};
            bitCnt_d = bitCnt_q + svi_pkg::BIT_STEP;
         end
      end else if (state_q != svi_pkg::ST_IDLE && sclFall) begin
         if (bitCnt_q == svi_pkg::BIT_ACK) begin
            // Byte complete: decide and drive the ninth bit
            oe_d = 1'b0;
            ackOurs_d = 1'b1;
            unique case (state_q)
               svi_pkg::ST_ADDR: begin
                  if (addrHit) begin
                     oe_d = 1'b1;
                     if (sh_q[svi_pkg::DIR_BIT]) begin
                        state_d = svi_pkg::ST_TX;
                        cntByte_d = blkRd_q;
                        cnt_d = svi_pkg::BLK_LEN;
                     end else begin
                        state_d = svi_pkg::ST_CMD;
                     end
                  end else begin
                     state_d = svi_pkg::ST_SKIP;
                  end
               end
               svi_pkg::ST_CMD: begin
                  // Busy or illegal code is refused, pointer untouched
                  state_d = svi_pkg::ST_SKIP;
                  if (!busy) begin
                     if (sh_q == svi_pkg::CMD_BLK_WR) begin
                        oe_d = 1'b1;
                        state_d = svi_pkg::ST_BCNT;
                     end else if (sh_q == svi_pkg::CMD_BLK_RD || sh_q == svi_pkg::CMD_REBOOT) begin
                        oe_d = 1'b1;
                        cmd_d = sh_q;
                        blkRd_d = (sh_q == svi_pkg::CMD_BLK_RD);
                        state_d = svi_pkg::ST_HOLD;
                     end else if (ptrLegal(sh_q)) begin
                        oe_d = 1'b1;
                        cmd_d = sh_q;
                        state_d = svi_pkg::ST_WDAT;
                     end
                  end
               end
               svi_pkg::ST_WDAT: begin
                  // Single byte write; location becomes the pointer
                  oe_d = 1'b1;
                  ptr_d = cmd_q;
                  wr_d = '{addr: cmd_q, data: sh_q};
                  state_d = svi_pkg::ST_SKIP;
                  if (cmd_q >= svi_pkg::EEP_LSB_LO && cmd_q <= svi_pkg::EEP_LSB_HI) begin
                     eep_d = 1'b1;
                  end else if (cmd_q != svi_pkg::REG_TOP) begin
                     wrStb_d = 1'b1;
                  end
               end
               svi_pkg::ST_BCNT: begin
                  // Count outside one to sixteen is refused
                  if (sh_q != 8'h00 && sh_q <= {3'h0, svi_pkg::BLK_LEN}) begin
                     oe_d = 1'b1;
                     cnt_d = sh_q[4:0];
                     state_d = svi_pkg::ST_BWR;
                  end else begin
                     state_d = svi_pkg::ST_SKIP;
                  end
               end
               svi_pkg::ST_BWR: begin
                  // Bytes beyond the count are refused
                  if (cnt_q != svi_pkg::CNT_ZERO) begin
                     oe_d = 1'b1;
                     cnt_d = cnt_q - svi_pkg::CNT_STEP;
                     wr_d = '{addr: ptr_q, data: sh_q};
                     wrStb_d = (ptr_q != svi_pkg::REG_TOP);
                     ptr_d = ptrNext(ptr_q);
                  end else begin
                     state_d = svi_pkg::ST_SKIP;
                  end
               end
               svi_pkg::ST_TX: begin
                  ackOurs_d = 1'b0;
               end
               svi_pkg::ST_IDLE, svi_pkg::ST_HOLD, svi_pkg::ST_SKIP: begin
                  state_d = svi_pkg::ST_SKIP;
               end
            endcase
         end else if (bitCnt_q == svi_pkg::BIT_ZERO) begin
            // Ninth clock over: release, then maybe send
            if (ackOurs_q) begin
               oe_d = 1'b0;
               ackOurs_d = 1'b0;
               if (state_q == svi_pkg::ST_TX) begin
                  tx_d = txLoad;
                  oe_d = !txLoad[7];
               end
            end else if (state_q == svi_pkg::ST_TX) begin
               if (mAck_q) begin
                  tx_d = txLoad;
                  oe_d = !txLoad[7];
               end else begin
                  oe_d = 1'b0;
                  state_d = svi_pkg::ST_SKIP;
               end
            end
         end else if (state_q == svi_pkg::ST_TX) begin
            // Open drain: drive only the zeros, msb first
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = !tx_q[6];
         end
      end
   end

   // Protocol registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= svi_pkg::ST_IDLE;
         bitCnt_q <= svi_pkg::BIT_ZERO;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         cmd_q <= 8'h00;
         ptr_q <= svi_pkg::PTR_RST;
         cnt_q <= svi_pkg::CNT_ZERO;
         oe_q <= 1'b0;
         ackOurs_q <= 1'b0;
         mAck_q <= 1'b0;
         blkRd_q <= 1'b0;
         cntByte_q <= 1'b0;
         wr_q <= '0;
         wrStb_q <= 1'b0;
         eep_q <= 1'b0;
         boot_q <= 1'b0;
         sdaOut <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         cmd_q <= cmd_d;
         ptr_q <= ptr_d;
         cnt_q <= cnt_d;
         oe_q <= oe_d;
         ackOurs_q <= ackOurs_d;
         mAck_q <= mAck_d;
         blkRd_q <= blkRd_d;
         cntByte_q <= cntByte_d;
         wr_q <= wr_d;
         wrStb_q <= wrStb_d;
         eep_q <= eep_d;
         boot_q <= boot_d;
         sdaOut <= 1'b0;
      end
   end

   assign sdaOe = oe_q;
   assign rdAddr = ptr_q;
   assign wrPort = wr_q;
   assign wrStb = wrStb_q;
   assign eepLsbLoad = eep_q;
   assign rebootReq = boot_q;

   // ==========================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_stop_idle: assert property (stopDet && clkEn |=> state_q == svi_pkg::ST_IDLE)
      else $error("stop did not return to idle");
   a_start_addr: assert property (startDet && clkEn |=> state_q == svi_pkg::ST_ADDR && !oe_q)
      else $error("start did not reopen address phase");
   a_busy_nack: assert property (clkEn && sclFall && !startDet && !stopDet && bitCnt_q == svi_pkg::BIT_ACK
      && state_q == svi_pkg::ST_CMD && busy |=> !oe_q && state_q == svi_pkg::ST_SKIP)
      else $error("command acknowledged while busy");
   a_foreign_nack: assert property (clkEn && sclFall && !startDet && !stopDet && bitCnt_q == svi_pkg::BIT_ACK
      && state_q == svi_pkg::ST_ADDR && !addrHit |=> !oe_q)
      else $error("foreign address acknowledged");
   a_top_readonly: assert property (wrStb_q |-> wrPort.addr != svi_pkg::REG_TOP)
      else $error("write to read-only top register");
   a_ptr_legal: assert property (ptrLegal(ptr_q))
      else $error("pointer outside legal ranges");
   a_ptr_sat: assert property (clkEn && state_q == svi_pkg::ST_BWR && ptr_q == svi_pkg::EEP_TOP
      |=> ptr_q == svi_pkg::EEP_TOP)
      else $error("pointer left the last location");
   a_blkwr_stop: assert property (clkEn && stopDet && state_q == svi_pkg::ST_BCNT
      |=> ptr_q == $past(ptr_q))
      else $error("stop after block code moved pointer");
   a_reboot_src: assert property ($rose(boot_q) |-> $past(stopDet) && $past(cmd_q) == svi_pkg::CMD_REBOOT)
      else $error("reboot without reboot code and stop");
endmodule // svi_slave
`default_nettype wire

/* bench/svi_master.sv */
// Two-wire bus master model facing the supervisor slave
`default_nettype none
module svi_master (
   input wire logic ref_clk, // System clock
   input wire logic sdaWire, // Resolved data line
   output var logic sclOut, // Serial clock, master owned
   output var logic sdaDrv // Data level, 1 releases the line
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // Bit timing
   localparam int HALF = 10; // Half bit in clocks; slow enough for the two-flop syncs
   initial begin
      sclOut = 1'h1; // Bus idle high
      sdaDrv = 1'h1;
   end
   // Half a bit, then settle just after the edge
   task automatic hp();
      repeat (HALF) @(posedge ref_clk);
      #1;
   endtask
   // ==========================================
   // Framing
   // Start or repeated start: data falls while clock is high
   task automatic startC();
      sdaDrv = 1'h1;
      hp();
      sclOut = 1'h1;
      hp();
      sdaDrv = 1'h0;
      hp();
      sclOut = 1'h0;
      hp();
   endtask
   // Stop: data rises while clock is high; clock then stays high
   task automatic stopC();
      sdaDrv = 1'h0;
      hp();
      sclOut = 1'h1;
      hp();
      sdaDrv = 1'h1;
      hp();
   endtask
   // One clock pulse; line sampled at the end of the high phase
   task automatic bitX(input logic v, output logic s);
      sdaDrv = v;
      hp();
      sclOut = 1'h1;
      hp();
      s = sdaWire;
      sclOut = 1'h0;
   endtask
   // Byte out MSB first, then the ninth clock with the line released
   task automatic wrByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitX(b[i], s);
      end
      bitX(1'h1, s);
      ack = ~s;
   endtask
   // Byte in, then our own acknowledge or refusal
   task automatic rdByte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitX(1'h1, d[i]);
      end
      bitX(nack, s);
   endtask
endmodule // svi_master
`default_nettype wire

/* bench/svi_slave_bench.sv */
// Self-checking bench of the supervisor two-wire slave
`default_nettype none
module svi_slave_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // Signals
   typedef struct packed {
      logic [7:0] code; // Command code
      logic [7:0] data; // Data byte
      logic ack; // Code should be acknowledged
      logic wr; // Register write strobe due
      logic ep; // EEPROM low-byte preset due
   } svi_row_s;
   localparam logic [7:0] AW = 8'ha4; // Write address with select pin high, fixed bit 3 low
   localparam logic [7:0] AR = 8'ha5; // Read address
   logic ref_clk, rst, clkEn, sdaOut, sdaOe, addrSelectPin, busy, wrStb, eepLsbLoad, rebootReq;
   logic sclOut, sdaDrv, sdaWire;
   logic [7:0] rdAddr, p0;
   svi_pkg::svi_wr_s wrPort, lastWr;
   logic [7:0] mem [256]; // Register bank and EEPROM image
   int err_total, n_tests, nWr, nEep, nBoot, cyc, w0, e0, b0;
   svi_row_s rows [8] = '{'{8'h00, 8'h5a, 1'h1, 1'h1, 1'h0}, '{8'h2e, 8'h3c, 1'h1, 1'h1, 1'h0},
      '{8'h2f, 8'h11, 1'h1, 1'h0, 1'h0}, '{8'h30, 8'h22, 1'h0, 1'h0, 1'h0}, '{8'h40, 8'h77, 1'h1, 1'h1, 1'h0},
      '{8'h80, 8'h12, 1'h1, 1'h0, 1'h1}, '{8'h82, 8'h34, 1'h1, 1'h0, 1'h1}, '{8'ha0, 8'h00, 1'h0, 1'h0, 1'h0}};
   // Open drain with pull-up: low if either party pulls
   assign sdaWire = sdaDrv & ~sdaOe;
   svi_slave svi_slave_inst (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .sclIn(sclOut), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectPin(addrSelectPin), .busy(busy), .rdData(mem[rdAddr]),
      .rdAddr(rdAddr), .wrPort(wrPort), .wrStb(wrStb), .eepLsbLoad(eepLsbLoad), .rebootReq(rebootReq));
   svi_master svi_master_inst (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclOut(sclOut), .sdaDrv(sdaDrv));
   always #2 ref_clk = ~ref_clk;
   // ==========================================
   // Helpers
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic [7:0] b, input logic exp);
      logic a;
      svi_master_inst.wrByte(b, a);
      chk("ack", {7'h0, a}, {7'h0, exp});
   endtask
   task automatic rb(input logic nack, input logic [7:0] exp);
      logic [7:0] d;
      svi_master_inst.rdByte(nack, d);
      chk("rdat", d, exp);
   endtask
   // Pointer preset by a lone byte
   task automatic pre(input logic [7:0] p);
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(p, 1'h1);
      svi_master_inst.stopC();
   endtask
   // Block write of n bytes from d0 upward
   task automatic bw(input logic [7:0] p, input logic [7:0] n, input logic [7:0] d0);
      pre(p);
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'hc0, 1'h1);
      wb(n, 1'h1);
      for (int k = 0; k < n; k++) begin
         wb(d0 + 8'(k), 1'h1);
      end
      svi_master_inst.stopC();
   endtask
   task automatic test_done();
      if (err_total == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Write side of the bank, strobe counts and the hang limit
   always @(posedge ref_clk) begin
      cyc++;
      if (wrStb === 1'h1) begin
         mem[wrPort.addr] <= wrPort.data;
         nWr++;
      end
      if (wrStb === 1'h1 || eepLsbLoad === 1'h1) begin
         lastWr <= wrPort;
      end
      if (eepLsbLoad === 1'h1) begin
         nEep++;
      end
      if (rebootReq === 1'h1) begin
         nBoot++;
      end
      if (cyc == 60000) begin
         err_total++;
         test_done();
      end
   end
   // ==========================================
   // Sequence
   initial begin
      ref_clk = 1'h0;
      rst = 1'h1;
      clkEn = 1'h1;
      busy = 1'h0;
      addrSelectPin = 1'h1;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h3c;
      end
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'h0;
      chk("oe", {7'h0, sdaOe}, 8'h00);
      chk("sdaOut", {7'h0, sdaOut}, 8'h00);
      chk("ptr", rdAddr, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1;
      // Write byte table
      for (int i = 0; i < 8; i++) begin
         w0 = nWr;
         e0 = nEep;
         svi_master_inst.startC();
         wb(AW, 1'h1);
         wb(rows[i].code, rows[i].ack);
         if (rows[i].ack) begin
            wb(rows[i].data, 1'h1);
         end
         svi_master_inst.stopC();
         chk("wr", 8'(nWr - w0), {7'h0, rows[i].wr});
         chk("eep", 8'(nEep - e0), {7'h0, rows[i].ep});
         if (rows[i].wr || rows[i].ep) begin
            chk("waddr", lastWr.addr, rows[i].code);
            chk("wdata", lastWr.data, rows[i].data);
         end
      end
      // Address decoding; each address differs from ours in one field only
      svi_master_inst.startC();
      wb(8'ha0, 1'h0);
      svi_master_inst.stopC();
      svi_master_inst.startC();
      wb(8'hb4, 1'h0);
      svi_master_inst.stopC();
      svi_master_inst.startC();
      wb(8'hac, 1'h0);
      svi_master_inst.stopC();
      svi_master_inst.startC();
      wb(8'ha6, 1'h1);
      svi_master_inst.stopC();
      // Select pin low flips which address bit two is ours
      addrSelectPin = 1'h0;
      svi_master_inst.startC();
      wb(8'ha0, 1'h1);
      svi_master_inst.stopC();
      svi_master_inst.startC();
      wb(8'ha4, 1'h0);
      svi_master_inst.stopC();
      addrSelectPin = 1'h1;
      // Preset, bare read, pointer advance
      pre(8'h45);
      chk("ptr", rdAddr, 8'h45);
      svi_master_inst.startC();
      wb(AR, 1'h1);
      rb(1'h1, 8'h79);
      svi_master_inst.stopC();
      chk("ptr", rdAddr, 8'h46);
      // Read byte with repeated start
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'h05, 1'h1);
      svi_master_inst.startC();
      wb(AR, 1'h1);
      rb(1'h1, 8'h39);
      svi_master_inst.stopC();
      chk("ptr", rdAddr, 8'h06);
      // Illegal preset, busy refusal, block code alone
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'h3a, 1'h0);
      svi_master_inst.stopC();
      busy = 1'h1;
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'h10, 1'h0);
      svi_master_inst.stopC();
      busy = 1'h0;
      chk("ptr", rdAddr, 8'h06);
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'hc0, 1'h1);
      svi_master_inst.stopC();
      chk("ptr", rdAddr, 8'h06);
      // Reboot
      b0 = nBoot;
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'hc4, 1'h1);
      svi_master_inst.stopC();
      chk("boot", 8'(nBoot - b0), 8'h01);
      // Block writes across boundaries
      bw(8'h2d, 8'h04, 8'ha1);
      chk("m2d", mem[8'h2d], 8'ha1);
      chk("m2e", mem[8'h2e], 8'ha2);
      chk("m2f", mem[8'h2f], 8'h13);
      bw(8'h9e, 8'h03, 8'hb1);
      chk("m9e", mem[8'h9e], 8'hb1);
      chk("m9f", mem[8'h9f], 8'hb3);
      bw(8'h7f, 8'h02, 8'hc1);
      chk("m80", mem[8'h80], 8'hc2);
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'hc0, 1'h1);
      wb(8'h11, 1'h0);
      svi_master_inst.stopC();
      // Block read, ended early by our refusal
      pre(8'h44);
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'hc1, 1'h1);
      svi_master_inst.startC();
      wb(AR, 1'h1);
      rb(1'h0, 8'h10);
      rb(1'h0, 8'h78);
      rb(1'h0, 8'h79);
      rb(1'h1, 8'h7a);
      svi_master_inst.stopC();
      chk("ptr", rdAddr, 8'h47);
      // Frozen engine ignores a whole frame; bus is idle when it wakes
      clkEn = 1'h0;
      svi_master_inst.startC();
      wb(AW, 1'h0);
      svi_master_inst.stopC();
      clkEn = 1'h1;
      chk("ptr", rdAddr, 8'h47);
      // Stop in mid-byte leaves nothing stored
      w0 = nWr;
      svi_master_inst.startC();
      wb(AW, 1'h1);
      wb(8'h10, 1'h1);
      for (int k = 0; k < 4; k++) begin
         svi_master_inst.bitX(1'h0, p0[0]);
      end
      svi_master_inst.stopC();
      chk("abort", 8'(nWr - w0), 8'h00);
      svi_master_inst.startC();
      wb(AW, 1'h1);
      svi_master_inst.stopC();
      test_done();
   end
endmodule // svi_slave_bench
`default_nettype wire
